/* File: stsoh_pkg.sv */
package stsoh_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] STSOH_IDX_MODE_CTRL  = 8'h30;
  localparam logic [7:0] STSOH_IDX_NU_R1C8    = 8'h31;
  localparam logic [7:0] STSOH_IDX_NU_R1C9    = 8'h32;
  localparam logic [7:0] STSOH_IDX_NU_R2C8    = 8'h33;
  localparam logic [7:0] STSOH_IDX_NU_R2C9    = 8'h34;
  localparam logic [7:0] STSOH_IDX_TRACE_CTRL = 8'h3a;
  localparam logic [7:0] STSOH_IDX_TRACE_DATA = 8'h3b;
  localparam logic [7:0] STSOH_IDX_NU_SRC     = 8'h62;
  localparam logic [7:0] STSOH_IDX_SRC_FOUR   = 8'h63;

  // field positions
  localparam int STSOH_BIT_STM1_MODE   = 0;
  localparam int STSOH_BIT_NU1_DEF_EN  = 5;
  localparam int STSOH_BIT_MD_R2C2     = 0;
  localparam int STSOH_BIT_MD_R2C3     = 1;
  localparam int STSOH_BIT_MD_R2C5     = 2;
  localparam int STSOH_BIT_UN_R2C6     = 3;
  localparam int STSOH_BIT_MD_R3C2     = 4;
  localparam int STSOH_BIT_PTR_RESET   = 0;
  localparam int STSOH_BIT_CPU_STEP    = 1;
  localparam int STSOH_POS_NU_R1C8     = 0;
  localparam int STSOH_POS_NU_R1C9     = 2;
  localparam int STSOH_POS_NU_R2C8     = 4;
  localparam int STSOH_POS_NU_R2C9     = 6;

  // reset values
  localparam logic [7:0] STSOH_RST_BYTE      = 8'h00;
  localparam logic [7:0] STSOH_RST_MODE_CTRL = 8'h01;

  // writable masks
  localparam logic [7:0] STSOH_MASK_MODE_CTRL  = 8'h21;
  localparam logic [7:0] STSOH_MASK_TRACE_CTRL = 8'h03;
  localparam logic [7:0] STSOH_MASK_SRC_FOUR   = 8'h1f;

  // j0 byte sent while the processor steps the pointer
  localparam logic [7:0] STSOH_J0_CPU_FILL = 8'h01;

  // overhead slot codes from the frame generator
  localparam logic [3:0] STSOH_SLOT_J0      = 4'h0;
  localparam logic [3:0] STSOH_SLOT_MD_R2C2 = 4'h1;
  localparam logic [3:0] STSOH_SLOT_MD_R2C3 = 4'h2;
  localparam logic [3:0] STSOH_SLOT_MD_R2C5 = 4'h3;
  localparam logic [3:0] STSOH_SLOT_UN_R2C6 = 4'h4;
  localparam logic [3:0] STSOH_SLOT_MD_R3C2 = 4'h5;
  localparam logic [3:0] STSOH_SLOT_NU_R1C8 = 4'h6;
  localparam logic [3:0] STSOH_SLOT_NU_R1C9 = 4'h7;
  localparam logic [3:0] STSOH_SLOT_NU_R2C8 = 4'h8;
  localparam logic [3:0] STSOH_SLOT_NU_R2C9 = 4'h9;

endpackage

/* File: stsoh_top.sv */
`timescale 1ns/100ps
module stsoh_top
  import stsoh_pkg::*;
#(
  parameter int         TRACE_LEN   = 16,
  parameter int         ADDR_W      = 12,
  parameter logic [7:0] NU1_DEFAULT = 8'h00
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // overhead slot stream from the frame generator
  input  wire logic              oh_slot_valid,
  input  wire logic [3:0]        oh_slot_id,
  input  wire logic [7:0]        serial_tx_overhead_input,
  input  wire logic [7:0]        rx_oh_byte,
  // transmitted overhead byte
  output logic                   tx_oh_valid,
  output logic [7:0]             tx_oh_byte
);

  localparam int PTR_W = (TRACE_LEN > 1) ? $clog2(TRACE_LEN) : 1;
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(TRACE_LEN - 1);

  // selects serial input for 0 and received byte for 1
  function automatic logic [7:0] pick_bit(input logic sel, input logic [7:0] ser,
                                          input logic [7:0] rcv);
    pick_bit = sel ? rcv : ser;
  endfunction

  // two-bit national field decode
  function automatic logic [7:0] pick_field(input logic [1:0] fld, input logic [7:0] cpu,
                                            input logic [7:0] ser, input logic [7:0] rcv);
    if (fld[1]) begin
      pick_field = rcv;
    end else if (fld[0]) begin
      pick_field = ser;
    end else begin
      pick_field = cpu;
    end
  endfunction

  function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p);
    ptr_step = (p == PTR_LAST) ? '0 : p + PTR_W'(1);
  endfunction

  logic [7:0] mode_ctrl_reg;
  logic [7:0] nu_r1c8_cpu_value;
  logic [7:0] nu_r1c9_cpu_value;
  logic [7:0] nu_r2c8_cpu_value;
  logic [7:0] nu_r2c9_cpu_value;
  logic [7:0] trace_ctrl_reg;
  logic [7:0] nu_src_reg;
  logic [7:0] src_four_reg;
  logic [7:0] trace_mem [TRACE_LEN];
  logic [PTR_W-1:0] trace_ptr_reg;

  logic       stm1_mode;
  logic       row1_national_default_enable;
  logic       trace_ptr_cpu_step;
  logic       trace_ptr_reset;
  logic       md_r3c2_source_sel;
  logic       unused_r2c6_source_sel;
  logic       md_r2c5_source_sel;
  logic       md_r2c3_source_sel;
  logic       md_r2c2_source_sel;
  logic [1:0] nu_r1c8_source_field;
  logic [1:0] nu_r1c9_source_field;
  logic [1:0] nu_r2c8_source_field;
  logic [1:0] nu_r2c9_source_field;
  logic [7:0] trace_string_byte;
  logic [7:0] nu1_cpu_or_default_c8;
  logic [7:0] nu1_cpu_or_default_c9;

  assign stm1_mode                    = mode_ctrl_reg[STSOH_BIT_STM1_MODE];
  assign row1_national_default_enable = mode_ctrl_reg[STSOH_BIT_NU1_DEF_EN];
  assign trace_ptr_cpu_step           = trace_ctrl_reg[STSOH_BIT_CPU_STEP];
  assign trace_ptr_reset              = trace_ctrl_reg[STSOH_BIT_PTR_RESET];
  assign md_r3c2_source_sel           = src_four_reg[STSOH_BIT_MD_R3C2];
  assign unused_r2c6_source_sel       = src_four_reg[STSOH_BIT_UN_R2C6];
  assign md_r2c5_source_sel           = src_four_reg[STSOH_BIT_MD_R2C5];
  assign md_r2c3_source_sel           = src_four_reg[STSOH_BIT_MD_R2C3];
  assign md_r2c2_source_sel           = src_four_reg[STSOH_BIT_MD_R2C2];
  assign nu_r1c8_source_field         = nu_src_reg[STSOH_POS_NU_R1C8 +: 2];
  assign nu_r1c9_source_field         = nu_src_reg[STSOH_POS_NU_R1C9 +: 2];
  assign nu_r2c8_source_field         = nu_src_reg[STSOH_POS_NU_R2C8 +: 2];
  assign nu_r2c9_source_field         = nu_src_reg[STSOH_POS_NU_R2C9 +: 2];
  assign trace_string_byte            = trace_mem[trace_ptr_reg];

  // ---------------- apb decode ----------------
  logic [7:0] reg_idx;
  logic       idx_hit;
  logic       apb_setup;
  logic       apb_done;
  logic       wr_done;
  logic       rd_done;

  assign reg_idx   = paddr[9:2];
  assign apb_setup = psel & ~penable;
  assign apb_done  = psel & penable;
  assign wr_done   = apb_done & pwrite & idx_hit;
  assign rd_done   = apb_done & ~pwrite & idx_hit;
  assign pready    = penable;

  always_comb begin
    idx_hit = 1'b0;
    if (paddr[1:0] == 2'b00 && paddr[ADDR_W-1:10] == '0) begin
      case (reg_idx)
        STSOH_IDX_MODE_CTRL,
        STSOH_IDX_NU_R1C8,
        STSOH_IDX_NU_R1C9,
        STSOH_IDX_NU_R2C8,
        STSOH_IDX_NU_R2C9,
        STSOH_IDX_TRACE_CTRL,
        STSOH_IDX_TRACE_DATA,
        STSOH_IDX_NU_SRC,
        STSOH_IDX_SRC_FOUR: idx_hit = 1'b1;
        default:            idx_hit = 1'b0;
      endcase
    end
  end

  assign pslverr = apb_done & ~idx_hit;

  logic [7:0] rd_value;

  always_comb begin
    rd_value = 8'h00;
    case (reg_idx)
      STSOH_IDX_MODE_CTRL:  rd_value = mode_ctrl_reg;
      STSOH_IDX_NU_R1C8:    rd_value = nu_r1c8_cpu_value;
      STSOH_IDX_NU_R1C9:    rd_value = nu_r1c9_cpu_value;
      STSOH_IDX_NU_R2C8:    rd_value = nu_r2c8_cpu_value;
      STSOH_IDX_NU_R2C9:    rd_value = nu_r2c9_cpu_value;
      STSOH_IDX_TRACE_CTRL: rd_value = trace_ctrl_reg;
      STSOH_IDX_TRACE_DATA: rd_value = trace_string_byte;
      STSOH_IDX_NU_SRC:     rd_value = nu_src_reg;
      STSOH_IDX_SRC_FOUR:   rd_value = src_four_reg;
      default:              rd_value = 8'h00;
    endcase
  end

  // read data is captured in the setup cycle and held through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (apb_setup) begin
      prdata <= (idx_hit && !pwrite) ? {24'h0, rd_value} : 32'h0;
    end
  end

  // ---------------- configuration registers ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ctrl_reg <= STSOH_RST_MODE_CTRL;
    end else if (wr_done && reg_idx == STSOH_IDX_MODE_CTRL) begin
      mode_ctrl_reg <= pwdata[7:0] & STSOH_MASK_MODE_CTRL;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nu_r1c8_cpu_value <= STSOH_RST_BYTE;
      nu_r1c9_cpu_value <= STSOH_RST_BYTE;
      nu_r2c8_cpu_value <= STSOH_RST_BYTE;
      nu_r2c9_cpu_value <= STSOH_RST_BYTE;
    end else if (wr_done) begin
      if (reg_idx == STSOH_IDX_NU_R1C8) begin
        nu_r1c8_cpu_value <= pwdata[7:0];
      end
      if (reg_idx == STSOH_IDX_NU_R1C9) begin
        nu_r1c9_cpu_value <= pwdata[7:0];
      end
      if (reg_idx == STSOH_IDX_NU_R2C8) begin
        nu_r2c8_cpu_value <= pwdata[7:0];
      end
      if (reg_idx == STSOH_IDX_NU_R2C9) begin
        nu_r2c9_cpu_value <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nu_src_reg   <= STSOH_RST_BYTE;
      src_four_reg <= STSOH_RST_BYTE;
    end else if (wr_done) begin
      if (reg_idx == STSOH_IDX_NU_SRC) begin
        nu_src_reg <= pwdata[7:0];
      end
      if (reg_idx == STSOH_IDX_SRC_FOUR) begin
        src_four_reg <= pwdata[7:0] & STSOH_MASK_SRC_FOUR;
      end
    end
  end

  // ---------------- trace string control and pointer ----------------
  logic ctrl_wr;
  logic ptr_clear;
  logic data_access;
  logic j0_slot;
  logic frame_step;

  assign ctrl_wr     = wr_done && reg_idx == STSOH_IDX_TRACE_CTRL;
  // only a 0 to 1 change of the reset bit clears the pointer
  assign ptr_clear   = ctrl_wr && !trace_ptr_reset && pwdata[STSOH_BIT_PTR_RESET];
  assign data_access = (wr_done | rd_done) && reg_idx == STSOH_IDX_TRACE_DATA;
  assign j0_slot     = oh_slot_valid && oh_slot_id == STSOH_SLOT_J0;
  assign frame_step  = j0_slot && !trace_ptr_cpu_step;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trace_ctrl_reg <= STSOH_RST_BYTE;
    end else if (ctrl_wr) begin
      trace_ctrl_reg <= pwdata[7:0] & STSOH_MASK_TRACE_CTRL;
    end
  end

  // clearing wins over stepping in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trace_ptr_reg <= '0;
    end else if (ptr_clear) begin
      trace_ptr_reg <= '0;
    end else if (trace_ptr_cpu_step && data_access) begin
      trace_ptr_reg <= ptr_step(trace_ptr_reg);
    end else if (frame_step) begin
      trace_ptr_reg <= ptr_step(trace_ptr_reg);
    end
  end

  // string store; written at the current pointer entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < TRACE_LEN; i++) begin
        trace_mem[i] <= STSOH_RST_BYTE;
      end
    end else if (wr_done && reg_idx == STSOH_IDX_TRACE_DATA) begin
      trace_mem[trace_ptr_reg] <= pwdata[7:0];
    end
  end

  // ---------------- transmit byte selection ----------------
  assign nu1_cpu_or_default_c8 = row1_national_default_enable ? NU1_DEFAULT
                                                                : nu_r1c8_cpu_value;
  assign nu1_cpu_or_default_c9 = row1_national_default_enable ? NU1_DEFAULT
                                                                : nu_r1c9_cpu_value;

  logic [7:0] tx_sel;
  logic [7:0] ser;
  logic [7:0] rcv;

  assign ser = serial_tx_overhead_input;
  assign rcv = rx_oh_byte;

  always_comb begin
    tx_sel = ser;
    if (oh_slot_id == STSOH_SLOT_J0) begin
      tx_sel = trace_ptr_cpu_step ? STSOH_J0_CPU_FILL : trace_string_byte;
    end else if (stm1_mode) begin
      case (oh_slot_id)
        STSOH_SLOT_MD_R3C2: tx_sel = pick_bit(md_r3c2_source_sel, ser, rcv);
        STSOH_SLOT_UN_R2C6: tx_sel = pick_bit(unused_r2c6_source_sel, ser, rcv);
        STSOH_SLOT_MD_R2C5: tx_sel = pick_bit(md_r2c5_source_sel, ser, rcv);
        STSOH_SLOT_MD_R2C3: tx_sel = pick_bit(md_r2c3_source_sel, ser, rcv);
        STSOH_SLOT_MD_R2C2: tx_sel = pick_bit(md_r2c2_source_sel, ser, rcv);
        STSOH_SLOT_NU_R1C8:
          tx_sel = pick_field(nu_r1c8_source_field, nu1_cpu_or_default_c8, ser, rcv);
        STSOH_SLOT_NU_R1C9:
          tx_sel = pick_field(nu_r1c9_source_field, nu1_cpu_or_default_c9, ser, rcv);
        STSOH_SLOT_NU_R2C8:
          tx_sel = pick_field(nu_r2c8_source_field, nu_r2c8_cpu_value, ser, rcv);
        STSOH_SLOT_NU_R2C9:
          tx_sel = pick_field(nu_r2c9_source_field, nu_r2c9_cpu_value, ser, rcv);
        default:            tx_sel = ser;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_oh_valid <= 1'b0;
      tx_oh_byte  <= STSOH_RST_BYTE;
    end else begin
      tx_oh_valid <= oh_slot_valid;
      tx_oh_byte  <= oh_slot_valid ? tx_sel : STSOH_RST_BYTE;
    end
  end

endmodule

/* File: stsoh_top_properties.sv */
`timescale 1ns/100ps
module stsoh_top_props
  import stsoh_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb slave
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // overhead slots
  input wire logic              oh_slot_valid,
  input wire logic [3:0]        oh_slot_id,
  input wire logic [7:0]        serial_tx_overhead_input,
  input wire logic [7:0]        rx_oh_byte,
  input wire logic              tx_oh_valid,
  input wire logic [7:0]        tx_oh_byte
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence acc_s;
    psel && penable;
  endsequence
  sequence same_src_s;
    oh_slot_valid && serial_tx_overhead_input == rx_oh_byte && oh_slot_id inside {[4'h1:4'h5]};
  endsequence
  slot_echo_a: assert property (oh_slot_valid |=> tx_oh_valid)
    else $error("slot not echoed");
  idle_out_a: assert property (!oh_slot_valid |=> !tx_oh_valid && tx_oh_byte == 8'h00)
    else $error("output active without slot");
  same_src_a: assert property (
    same_src_s |=> tx_oh_byte == $past(rx_oh_byte)) else $error("selected byte wrong");
  odd_slot_a: assert property (oh_slot_valid && oh_slot_id > 4'h9
    |=> tx_oh_byte == $past(serial_tx_overhead_input)) else $error("unknown slot byte");
  zero_wait_a: assert property (acc_s |-> pready) else $error("access not ready");
  no_ready_a: assert property (!penable |-> !pready) else $error("ready outside access");
  rd_upper_a: assert property (acc_s |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  misalign_a: assert property (acc_s ##0 paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned not refused");
  err_read_a: assert property (acc_s ##0 (pslverr && !pwrite) |-> prdata == 32'h0)
    else $error("refused read not zero");
endmodule
bind stsoh_top stsoh_top_props #(.ADDR_W(ADDR_W)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .oh_slot_valid(oh_slot_valid), .oh_slot_id(oh_slot_id),
  .serial_tx_overhead_input(serial_tx_overhead_input), .rx_oh_byte(rx_oh_byte),
  .tx_oh_valid(tx_oh_valid), .tx_oh_byte(tx_oh_byte));

/* File: stsoh_frame_gen.sv */
`timescale 1ns/100ps
module stsoh_frame_gen (
  // clock
  input  wire logic pclk,
  // slot stream towards the block
  output logic       oh_slot_valid,
  output logic [3:0] oh_slot_id,
  output logic [7:0] serial_tx_overhead_input,
  output logic [7:0] rx_oh_byte
);
  initial begin
    oh_slot_valid = 1'b0;
    oh_slot_id = 4'h0;
    serial_tx_overhead_input = 8'h00;
    rx_oh_byte = 8'h00;
  end
  // one slot per call; byte lines show the inverse once the slot is over
  task automatic send(input logic [3:0] id, input logic [7:0] ser, input logic [7:0] rcv);
    @(posedge pclk);
    oh_slot_valid <= 1'b1;
    oh_slot_id <= id;
    serial_tx_overhead_input <= ser;
    rx_oh_byte <= rcv;
    @(posedge pclk);
    oh_slot_valid <= 1'b0;
    serial_tx_overhead_input <= ~ser;
    rx_oh_byte <= ~rcv;
  endtask
endmodule

/* File: stsoh_tb_top.sv */
`timescale 1ns/100ps
module stsoh_tb_top
  import stsoh_pkg::*;
;
  localparam int         LEN = 4;
  localparam logic [7:0] DEF = 8'h6b;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, vld, tx_vld;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  sid;
  logic [7:0]  ser, rcv, tx_b;
  int          fail_count, num_checks;
  stsoh_top #(.TRACE_LEN(LEN), .ADDR_W(12), .NU1_DEFAULT(DEF)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .oh_slot_valid(vld), .oh_slot_id(sid), .serial_tx_overhead_input(ser),
    .rx_oh_byte(rcv), .tx_oh_valid(tx_vld), .tx_oh_byte(tx_b));
  stsoh_frame_gen gen (.pclk(pclk), .oh_slot_valid(vld), .oh_slot_id(sid),
    .serial_tx_overhead_input(ser), .rx_oh_byte(rcv));
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a wait for ready
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {2'b00, idx, 2'b00}, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    apb(1'b0, {2'b00, idx, 2'b00}, 8'h00);
    chk(q, e);
  endtask
  task automatic slot(input logic [3:0] id, input logic [7:0] e);
    gen.send(id, 8'h5a, 8'ha5);
    #1;
    chk({23'h0, tx_vld, tx_b}, {23'h0, 1'b1, e});
  endtask
  task automatic t_regs;
    rd(STSOH_IDX_MODE_CTRL, {24'h0, STSOH_RST_MODE_CTRL});
    for (int i = 0; i < 4; i++) rd(STSOH_IDX_NU_R1C8 + 8'(i), 32'h0);
    rd(STSOH_IDX_NU_SRC, 32'h0);
    rd(STSOH_IDX_TRACE_CTRL, 32'h0);
    wr(STSOH_IDX_SRC_FOUR, 8'hff);
    rd(STSOH_IDX_SRC_FOUR, 32'h1f);
    wr(STSOH_IDX_MODE_CTRL, 8'hff);
    rd(STSOH_IDX_MODE_CTRL, 32'h21);
    wr(STSOH_IDX_MODE_CTRL, 8'h01);
    apb(1'b0, 12'h0c6, 8'h00);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 12'h100, 8'h77);
    chk({31'h0, err}, 32'h1);
  endtask
  task automatic t_sel;
    for (int b = 0; b < 5; b++) begin
      wr(STSOH_IDX_SRC_FOUR, 8'h01 << b);
      for (int s = 1; s < 6; s++) slot(4'(s), (s - 1 == b) ? 8'ha5 : 8'h5a);
    end
    gen.send(4'h5, 8'h3c, 8'h3c);
    wr(STSOH_IDX_MODE_CTRL, 8'h00);
    wr(STSOH_IDX_SRC_FOUR, 8'h1f);
    for (int s = 1; s < 10; s++) slot(4'(s), 8'h5a);
    wr(STSOH_IDX_MODE_CTRL, 8'h01);
    wr(STSOH_IDX_SRC_FOUR, 8'h00);
    slot(4'hc, 8'h5a);
  endtask
  task automatic t_nu;
    for (int i = 0; i < 4; i++) wr(STSOH_IDX_NU_R1C8 + 8'(i), 8'h30 + 8'(i));
    for (int c = 0; c < 4; c++) begin
      wr(STSOH_IDX_NU_SRC, {4{2'(c)}});
      for (int i = 0; i < 4; i++) slot(STSOH_SLOT_NU_R1C8 + 4'(i),
        c == 0 ? 8'h30 + 8'(i) : (c == 1 ? 8'h5a : 8'ha5));
    end
    wr(STSOH_IDX_NU_SRC, 8'h00);
    wr(STSOH_IDX_MODE_CTRL, 8'h21);
    for (int i = 0; i < 4; i++) slot(STSOH_SLOT_NU_R1C8 + 4'(i), i < 2 ? DEF : 8'h30 + 8'(i));
    wr(STSOH_IDX_MODE_CTRL, 8'h01);
  endtask
  task automatic t_trace;
    wr(STSOH_IDX_TRACE_CTRL, 8'h02);
    wr(STSOH_IDX_TRACE_CTRL, 8'h03);
    for (int i = 0; i < LEN; i++) wr(STSOH_IDX_TRACE_DATA, 8'hc0 + 8'(i));
    slot(STSOH_SLOT_J0, STSOH_J0_CPU_FILL);
    for (int i = 0; i <= LEN; i++) rd(STSOH_IDX_TRACE_DATA, 32'hc0 + 32'(i % LEN));
    wr(STSOH_IDX_TRACE_CTRL, 8'h03);
    rd(STSOH_IDX_TRACE_DATA, 32'hc1);
    wr(STSOH_IDX_TRACE_CTRL, 8'h00);
    wr(STSOH_IDX_TRACE_CTRL, 8'h01);
    for (int i = 0; i <= LEN; i++) slot(STSOH_SLOT_J0, 8'hc0 + 8'(i % LEN));
  endtask
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    #40000;
    fail_count++;
    close_out;
  end
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    presetn = 1'b0;
    fail_count = 0;
    num_checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_sel;
    t_nu;
    t_trace;
    close_out;
  end
endmodule
